// ===== core/omc_cmd_gate.sv
// Classifies debug commands against the present operating mode.
`include "omc_consts.svh"

module omc_cmd_gate (
  // Command in
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  // Context
  input wire omc_pkg::omc_mode_t mode,
  input wire logic stop_dbg,
  // Verdict
  output logic accept,
  output logic error,
  output logic halt_go,
  output logic resume_go,
  output logic trace_go
);
  wire is_mem = (cmd_code == `OMC_CMD_MEM);
  wire is_stat = (cmd_code == `OMC_CMD_MEM_STAT);
  wire is_dreg = (cmd_code == `OMC_CMD_DBG_REG);
  wire is_halt = (cmd_code == `OMC_CMD_HALT);
  wire is_active = (cmd_code == `OMC_CMD_CPU_REG) || (cmd_code == `OMC_CMD_TRACE) ||
                   (cmd_code == `OMC_CMD_RESUME);
  wire non_intr = is_mem || is_stat || is_dreg || is_halt;
  wire in_run = (mode == omc_pkg::OMC_ST_RUN);
  wire in_halt = (mode == omc_pkg::OMC_ST_HALT);
  wire in_wait = (mode == omc_pkg::OMC_ST_WAIT);
  // A stop without debug entry has no debug clock, so nothing is heard there.
  wire in_stop = (mode == omc_pkg::OMC_ST_LSTOP) && stop_dbg;
  wire sleepy = in_wait || in_stop;

  assign accept = cmd_valid && ((in_run && non_intr) ||
                                (in_halt && (non_intr || is_active)) ||
                                (sleepy && (is_halt || is_stat)));
  assign error = cmd_valid && sleepy && is_stat;
  assign halt_go = cmd_valid && is_halt && (in_run || sleepy);
  assign resume_go = cmd_valid && in_halt && (cmd_code == `OMC_CMD_RESUME);
  assign trace_go = cmd_valid && in_halt && (cmd_code == `OMC_CMD_TRACE);
endmodule

// ===== core/omc_consts.svh
// Register offsets, field positions, reset values and command codes of the operating mode controller.
`ifndef OMC_CONSTS_SVH
`define OMC_CONSTS_SVH

`define OMC_OFF_CFG 12'h000
`define OMC_OFF_PMC 12'h004
`define OMC_OFF_STAT 12'h008

`define OMC_CFG_STOP_EN 0
`define OMC_CFG_PPD_SEL 1
`define OMC_CFG_LVD_EN 2
`define OMC_CFG_LVD_STOP 3
`define OMC_CFG_DBG_EN 4
`define OMC_CFG_RTI_KEEP 5
`define OMC_CFG_ADC_KEEP 6
`define OMC_CFG_ICS_KEEP 7
`define OMC_CFG_RESET 8'h00

`define OMC_PMC_FLAG 0
`define OMC_PMC_ACK 1
`define OMC_PMC_LATCH 2

`define OMC_RESET_VECTOR 16'hFFFE

`define OMC_CMD_MEM 3'h0
`define OMC_CMD_MEM_STAT 3'h1
`define OMC_CMD_DBG_REG 3'h2
`define OMC_CMD_HALT 3'h3
`define OMC_CMD_CPU_REG 3'h4
`define OMC_CMD_TRACE 3'h5
`define OMC_CMD_RESUME 3'h6

`define OMC_RESP_OKAY 2'h0
`define OMC_RESP_SLVERR 2'h2

`endif

// ===== core/omc_pkg.sv
// Types shared by the operating mode controller files.
package omc_pkg;
  typedef enum logic [2:0] {
    OMC_ST_RESET,
    OMC_ST_RUN,
    OMC_ST_HALT,
    OMC_ST_WAIT,
    OMC_ST_LSTOP,
    OMC_ST_DSTOP
  } omc_mode_t;
endpackage

// ===== core/omc_top.sv
// Operating mode controller: run, debug halt, wait and two stop modes behind an AXI4-Lite slave.
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`include "omc_consts.svh"

module omc_top (
  // Clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  // AXI4-Lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Processor events
  input wire logic mode_select_debug_pin,
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire logic break_to_debug_instruction,
  input wire logic breakpoint_hit,
  input wire logic irq_request,
  // Wake sources
  input wire logic periodic_wakeup_interrupt,
  input wire logic lowvolt_interrupt,
  input wire logic adc_interrupt,
  input wire logic irq_pin_n,
  input wire logic keypad_interrupt,
  // Debug command port
  input wire logic dbg_cmd_valid,
  input wire logic [2:0] dbg_cmd_code,
  output logic dbg_cmd_accept,
  output logic dbg_cmd_error,
  // Processor control
  output logic cpu_clk_en,
  output logic cpu_halted,
  output logic cpu_step,
  output logic vector_fetch,
  output logic [15:0] vector_addr,
  output logic clear_int_mask,
  output logic irq_resume,
  output logic illegal_op_reset,
  output logic sys_reset_req,
  // Power and clocks
  output logic periph_clk_en,
  output logic debug_clk_en,
  output logic regulator_full,
  output logic core_power_off,
  output logic adc_standby,
  output logic adc_run_en,
  output logic rti_run_en,
  output logic ics_run_en,
  output logic irq_force_low,
  output logic pin_latch_en
);
  omc_pkg::omc_mode_t st_q, st_d;
  logic [7:0] cfg_q;
  logic stop_dbg_q, stop_dbg_d;
  logic flag_q, latch_q, in_deep_q;
  logic aw_have_q, w_have_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic step_d, vec_d, clr_d, resume_d, ill_d, sysrst_d;

  // Command verdict for the present mode.
  logic c_acc, c_err, c_halt, c_resume, c_trace;
  omc_cmd_gate u_gate (
    .cmd_valid(dbg_cmd_valid),
    .cmd_code(dbg_cmd_code),
    .mode(st_q),
    .stop_dbg(stop_dbg_q),
    .accept(c_acc),
    .error(c_err),
    .halt_go(c_halt),
    .resume_go(c_resume),
    .trace_go(c_trace)
  );

  // Stop selection from configuration.
  wire stop_en = cfg_q[`OMC_CFG_STOP_EN];
  wire dbg_en = cfg_q[`OMC_CFG_DBG_EN];
  wire lvd_in_stop = cfg_q[`OMC_CFG_LVD_EN] && cfg_q[`OMC_CFG_LVD_STOP];
  wire go_deep = cfg_q[`OMC_CFG_PPD_SEL] && !lvd_in_stop && !dbg_en;
  wire light_wake = periodic_wakeup_interrupt || lowvolt_interrupt || adc_interrupt ||
                    !irq_pin_n || keypad_interrupt;
  wire deep_wake = periodic_wakeup_interrupt || !irq_pin_n;
  wire halt_entry = c_halt || break_to_debug_instruction || breakpoint_hit;

  // Register bus decode.
  wire wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  wire wr_cfg = wr_go && (aw_addr_q[11:2] == 10'(`OMC_OFF_CFG >> 2));
  wire wr_pmc = wr_go && (aw_addr_q[11:2] == 10'(`OMC_OFF_PMC >> 2));
  wire wr_stat = wr_go && (aw_addr_q[11:2] == 10'(`OMC_OFF_STAT >> 2));
  wire wr_hit = wr_cfg || wr_pmc || wr_stat;
  wire ack_wr = wr_pmc && w_strb_q[0] && w_data_q[`OMC_PMC_ACK];
  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire rd_cfg = (s_axi_araddr[11:2] == 10'(`OMC_OFF_CFG >> 2));
  wire rd_pmc = (s_axi_araddr[11:2] == 10'(`OMC_OFF_PMC >> 2));
  wire rd_stat = (s_axi_araddr[11:2] == 10'(`OMC_OFF_STAT >> 2));
  wire rd_hit = rd_cfg || rd_pmc || rd_stat;
  wire [31:0] pmc_word = {29'h0, latch_q, 1'b0, flag_q};
  wire [31:0] rd_word = rd_cfg ? {24'h0, cfg_q} :
                        rd_pmc ? pmc_word :
                        rd_stat ? {29'h0, st_q} : 32'h0000_0000;

  // Next mode and one-cycle strobes.
  always_comb begin
    st_d = st_q;
    stop_dbg_d = stop_dbg_q;
    step_d = 1'b0;
    vec_d = 1'b0;
    clr_d = 1'b0;
    resume_d = 1'b0;
    ill_d = 1'b0;
    sysrst_d = 1'b0;
    case (st_q)
      omc_pkg::OMC_ST_RESET: begin
        // The strap is sampled on the first edge after release, never by the reset itself.
        if (mode_select_debug_pin) begin
          st_d = omc_pkg::OMC_ST_RUN;
          vec_d = 1'b1;
        end else begin
          st_d = omc_pkg::OMC_ST_HALT;
        end
      end
      omc_pkg::OMC_ST_RUN: begin
        if (halt_entry) begin
          st_d = omc_pkg::OMC_ST_HALT;
        end else if (wait_exec) begin
          st_d = omc_pkg::OMC_ST_WAIT;
          clr_d = 1'b1;
        end else if (stop_exec && !stop_en) begin
          ill_d = 1'b1;
        end else if (stop_exec) begin
          stop_dbg_d = dbg_en;
          st_d = go_deep ? omc_pkg::OMC_ST_DSTOP : omc_pkg::OMC_ST_LSTOP;
        end
      end
      omc_pkg::OMC_ST_HALT: begin
        step_d = c_trace;
        if (c_resume) begin
          st_d = omc_pkg::OMC_ST_RUN;
        end
      end
      omc_pkg::OMC_ST_WAIT: begin
        if (c_halt) begin
          st_d = omc_pkg::OMC_ST_HALT;
        end else if (irq_request) begin
          st_d = omc_pkg::OMC_ST_RUN;
          resume_d = 1'b1;
        end
      end
      omc_pkg::OMC_ST_LSTOP: begin
        if (c_halt) begin
          st_d = omc_pkg::OMC_ST_HALT;
          stop_dbg_d = 1'b0;
        end else if (light_wake) begin
          st_d = omc_pkg::OMC_ST_RUN;
          resume_d = 1'b1;
          stop_dbg_d = 1'b0;
        end
      end
      omc_pkg::OMC_ST_DSTOP: begin
        if (deep_wake) begin
          st_d = omc_pkg::OMC_ST_RESET;
          sysrst_d = 1'b1;
        end
      end
      default: begin
        st_d = omc_pkg::OMC_ST_RESET;
      end
    endcase
  end

  // Mode register and processor strobes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= omc_pkg::OMC_ST_RESET;
      stop_dbg_q <= 1'b0;
      cpu_step <= 1'b0;
      vector_fetch <= 1'b0;
      vector_addr <= `OMC_RESET_VECTOR;
      clear_int_mask <= 1'b0;
      irq_resume <= 1'b0;
      illegal_op_reset <= 1'b0;
      sys_reset_req <= 1'b0;
      dbg_cmd_accept <= 1'b0;
      dbg_cmd_error <= 1'b0;
    end else begin
      st_q <= st_d;
      stop_dbg_q <= stop_dbg_d;
      cpu_step <= step_d;
      vector_fetch <= vec_d;
      vector_addr <= `OMC_RESET_VECTOR;
      clear_int_mask <= clr_d;
      irq_resume <= resume_d;
      illegal_op_reset <= ill_d;
      sys_reset_req <= sysrst_d;
      dbg_cmd_accept <= c_acc;
      dbg_cmd_error <= c_err;
    end
  end

  // Clock and power controls follow the next mode so they change with it.
  wire nx_stop = (st_d == omc_pkg::OMC_ST_LSTOP) || (st_d == omc_pkg::OMC_ST_DSTOP);
  wire nx_light = (st_d == omc_pkg::OMC_ST_LSTOP);
  wire nx_deep = (st_d == omc_pkg::OMC_ST_DSTOP);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_clk_en <= 1'b0;
      cpu_halted <= 1'b0;
      periph_clk_en <= 1'b1;
      debug_clk_en <= 1'b1;
      regulator_full <= 1'b1;
      core_power_off <= 1'b0;
      adc_standby <= 1'b0;
      adc_run_en <= 1'b1;
      rti_run_en <= 1'b1;
      ics_run_en <= 1'b1;
      irq_force_low <= 1'b0;
    end else begin
      cpu_clk_en <= (st_d == omc_pkg::OMC_ST_RUN);
      cpu_halted <= (st_d == omc_pkg::OMC_ST_HALT);
      periph_clk_en <= !nx_stop && (st_d != omc_pkg::OMC_ST_RESET);
      debug_clk_en <= !nx_stop || stop_dbg_d;
      regulator_full <= !nx_stop || stop_dbg_d;
      core_power_off <= nx_deep;
      adc_standby <= nx_deep || (nx_light && !cfg_q[`OMC_CFG_ADC_KEEP]);
      adc_run_en <= !nx_stop || (nx_light && cfg_q[`OMC_CFG_ADC_KEEP]);
      rti_run_en <= !nx_stop || cfg_q[`OMC_CFG_RTI_KEEP];
      ics_run_en <= !nx_stop || (nx_light && (cfg_q[`OMC_CFG_ICS_KEEP] || stop_dbg_d));
      irq_force_low <= nx_deep;
    end
  end

  // Configuration returns to defaults on a deep wake, as after power-on.
  always_ff @(posedge aclk) begin
    if (!aresetn || sysrst_d) begin
      cfg_q <= `OMC_CFG_RESET;
    end else if (wr_cfg && w_strb_q[0]) begin
      cfg_q <= w_data_q[7:0];
    end
  end

  // Recovery flag and pin latches live on power-on reset only, so a reset-pin wake keeps them.
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      flag_q <= 1'b0;
      latch_q <= 1'b0;
      in_deep_q <= 1'b0;
      pin_latch_en <= 1'b0;
    end else begin
      if (!aresetn && in_deep_q) begin
        in_deep_q <= 1'b0;
        flag_q <= 1'b1;
      end else if (aresetn && sysrst_d) begin
        in_deep_q <= 1'b0;
        flag_q <= 1'b1;
      end else if (aresetn && ack_wr) begin
        flag_q <= 1'b0;
      end
      if (aresetn && nx_deep && !in_deep_q) begin
        in_deep_q <= 1'b1;
      end
      // A wake in the cycle of an ack keeps the latch closed: in_deep_q is still set and blocks the clear.
      if (aresetn && nx_deep) begin
        latch_q <= 1'b1;
        pin_latch_en <= 1'b1;
      end else if (aresetn && ack_wr && !in_deep_q) begin
        latch_q <= 1'b0;
        pin_latch_en <= 1'b0;
      end
    end
  end

  // Write channel: address and data are taken in either order, one write at a time.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `OMC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `OMC_RESP_OKAY : `OMC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel: one read at a time, answered on the same edge that takes the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `OMC_RESP_OKAY;
    end else begin
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `OMC_RESP_OKAY : `OMC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// ===== testbench/omc_host_model.sv
// Debug host and IRQ wake pin model facing the controller.
module omc_host_model (
  // Clock
  input wire logic aclk,
  // Bench requests
  input wire logic req,
  input wire logic [2:0] req_code,
  input wire logic irq_low,
  // Toward the controller
  output logic dbg_cmd_valid,
  output logic [2:0] dbg_cmd_code,
  output logic irq_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] idle_q = 3'h5;
  // Between commands the code lines carry a moving pattern, so a stale code is never mistaken for a new one.
  always @(posedge aclk) begin
    idle_q <= ~idle_q;
  end
  assign dbg_cmd_valid = req;
  assign dbg_cmd_code = req ? req_code : idle_q;
  // A pull-up is fitted, so the released pin reads high.
  assign irq_pin_n = !irq_low;
endmodule

// ===== testbench/omc_top_properties.sv
// Concurrent checks on the operating mode controller ports.
`include "omc_consts.svh"
module omc_top_checker (
  // Clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  // Inputs
  input wire logic s_axi_wvalid,
  input wire logic mode_select_debug_pin,
  input wire logic wait_exec,
  input wire logic break_to_debug_instruction,
  input wire logic breakpoint_hit,
  input wire logic irq_pin_n,
  input wire logic dbg_cmd_valid,
  input wire logic [2:0] dbg_cmd_code,
  // Outputs
  input wire logic dbg_cmd_accept,
  input wire logic cpu_clk_en,
  input wire logic cpu_halted,
  input wire logic vector_fetch,
  input wire logic clear_int_mask,
  input wire logic regulator_full,
  input wire logic core_power_off,
  input wire logic irq_force_low,
  input wire logic pin_latch_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire logic cmd_mem = dbg_cmd_valid && dbg_cmd_code == `OMC_CMD_MEM;
  wire logic halt_cmd = dbg_cmd_valid && dbg_cmd_code == `OMC_CMD_HALT;
  wire logic halt_ev = break_to_debug_instruction || breakpoint_hit || halt_cmd;
  property p_run_start;
    $rose(aresetn) && mode_select_debug_pin |=> vector_fetch && cpu_clk_en;
  endproperty
  a_run_start: assert property (p_run_start) else $error("no run start");
  property p_nonintr;
    cmd_mem && cpu_clk_en |=> dbg_cmd_accept;
  endproperty
  a_nonintr: assert property (p_nonintr) else $error("memory command refused in run");
  property p_resume_refused;
    dbg_cmd_valid && dbg_cmd_code == `OMC_CMD_RESUME && !cpu_halted |=> !dbg_cmd_accept;
  endproperty
  a_resume_refused: assert property (p_resume_refused) else $error("resume taken outside halt");
  property p_lowpwr_mem;
    cmd_mem && !cpu_clk_en && !cpu_halted |=> !dbg_cmd_accept;
  endproperty
  a_lowpwr_mem: assert property (p_lowpwr_mem) else $error("memory command taken in low power");
  property p_wait_entry;
    wait_exec && cpu_clk_en && !halt_ev |=> clear_int_mask && !cpu_clk_en && !cpu_halted;
  endproperty
  a_wait_entry: assert property (p_wait_entry) else $error("bad wait entry");
  property p_deep_state;
    core_power_off |-> pin_latch_en && !regulator_full && irq_force_low;
  endproperty
  a_deep_state: assert property (p_deep_state) else $error("bad deep stop outputs");
  property p_irq_wake;
    core_power_off && !irq_pin_n |-> ##[1:4] !core_power_off;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("no wake on irq pin");
  property p_latch_hold;
    pin_latch_en && por_n && !s_axi_wvalid && !$past(s_axi_wvalid) |=> pin_latch_en;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("pin latch opened without write");
endmodule

bind omc_top omc_top_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .por_n(por_n), .s_axi_wvalid(s_axi_wvalid),
  .mode_select_debug_pin(mode_select_debug_pin), .wait_exec(wait_exec),
  .break_to_debug_instruction(break_to_debug_instruction), .breakpoint_hit(breakpoint_hit),
  .irq_pin_n(irq_pin_n), .dbg_cmd_valid(dbg_cmd_valid), .dbg_cmd_code(dbg_cmd_code),
  .dbg_cmd_accept(dbg_cmd_accept), .cpu_clk_en(cpu_clk_en), .cpu_halted(cpu_halted),
  .vector_fetch(vector_fetch), .clear_int_mask(clear_int_mask), .regulator_full(regulator_full),
  .core_power_off(core_power_off), .irq_force_low(irq_force_low), .pin_latch_en(pin_latch_en)
);

// ===== testbench/operating_mode_controller_bench.sv
// Self-checking bench of the operating mode controller.
`include "omc_consts.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module operating_mode_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, por_n = 0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1, ev = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic mode_select_debug_pin = 1, irq_request = 0, periodic_wakeup_interrupt = 0, lowvolt_interrupt = 0;
  logic adc_interrupt = 0, keypad_interrupt = 0, req = 0, irq_low = 0, h;
  logic [2:0] req_code = '0, dbg_cmd_code, c;
  logic wait_exec, stop_exec, break_to_debug_instruction, breakpoint_hit, irq_pin_n, dbg_cmd_valid;
  logic dbg_cmd_accept, dbg_cmd_error, cpu_clk_en, cpu_halted, cpu_step, vector_fetch, clear_int_mask;
  logic irq_resume, illegal_op_reset, sys_reset_req, periph_clk_en, debug_clk_en, regulator_full;
  logic core_power_off, adc_standby, adc_run_en, rti_run_en, ics_run_en, irq_force_low, pin_latch_en;
  logic [15:0] vector_addr;
  logic [33:0] d;
  int num_errors = 0, checks_done = 0, seed = 53, i;
  assign {breakpoint_hit, break_to_debug_instruction, stop_exec, wait_exec} = ev;
  omc_top dut (.*);
  omc_host_model host (.aclk(aclk), .req(req), .req_code(req_code), .irq_low(irq_low),
    .dbg_cmd_valid(dbg_cmd_valid), .dbg_cmd_code(dbg_cmd_code), .irq_pin_n(irq_pin_n));
  always #4 aclk = ~aclk;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic timeout();
    num_errors++;
    $display("mismatch answer exp 1 got 0");
    stop_test();
  endtask
  function automatic logic exp_acc(input logic hl, input logic [2:0] cc);
    return hl || cc < 3'h4;
  endfunction
  function automatic logic pick(input int s);
    case (s)
      0: return irq_resume;
      1: return sys_reset_req;
      default: return cpu_clk_en;
    endcase
  endfunction
  task automatic wait_on(input int s);
    int n;
    n = 0;
    while (pick(s) !== 1'b1 && n < 40) begin
      @(posedge aclk);
      #1;
      n++;
    end
    if (n >= 40) timeout();
  endtask
  task automatic do_reset(input logic pin);
    aresetn <= 0;
    por_n <= 0;
    mode_select_debug_pin <= pin;
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    por_n <= 1;
    // The vector strobe stands for the single cycle after the first edge of release.
    @(posedge aclk);
    #1;
  endtask
  task automatic cmd(input logic [2:0] cc);
    @(posedge aclk);
    req <= 1;
    req_code <= cc;
    @(posedge aclk);
    req <= 0;
    #1;
  endtask
  task automatic pulse(input logic [3:0] v);
    @(posedge aclk);
    ev <= v;
    @(posedge aclk);
    ev <= '0;
    #1;
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] wd, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 0;
    if (n >= 40) timeout();
    `CHK("bresp", er, s_axi_bresp)
  endtask
  task automatic axr(input logic [11:0] a, output logic [33:0] rd);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid && n < 40);
    s_axi_rready <= 0;
    rd = {s_axi_rresp, s_axi_rdata};
    if (n >= 40) timeout();
  endtask
  initial begin
    do_reset(0);
    `CHK("strap halt", 1'b1, cpu_halted)
    do_reset(1);
    `CHK("vector", 1'b1, vector_fetch)
    `CHK("vaddr", 16'hfffe, vector_addr)
    `CHK("run", 1'b1, cpu_clk_en)
    axr(`OMC_OFF_CFG, d);
    `CHK("cfg", 34'h0, d)
    axr(12'hffc, d);
    `CHK("unmapped", {2'h2, 32'h0}, d)
    axw(12'hffc, 32'h0000_0001, 2'h2);
    $display("done: reset");
    h = 0;
    for (i = 0; i < 24; i++) begin
      c = (i < 7) ? 3'((i + 4) % 7) : 3'($unsigned($random(seed)) % 7);
      cmd(c);
      `CHK("accept", exp_acc(h, c), dbg_cmd_accept)
      `CHK("step", h && c == `OMC_CMD_TRACE, cpu_step)
      if (c == `OMC_CMD_HALT) h = 1;
      if (c == `OMC_CMD_RESUME) h = 0;
      `CHK("halted", h, cpu_halted)
      `CHK("cpu clock", !h, cpu_clk_en)
    end
    cmd(`OMC_CMD_RESUME);
    for (i = 0; i < 2; i++) begin
      pulse(4'h4 << i);
      `CHK("break", 1'b1, cpu_halted)
      cmd(`OMC_CMD_RESUME);
    end
    $display("done: commands");
    pulse(4'h1);
    `CHK("int mask", 1'b1, clear_int_mask)
    `CHK("wait clock", 1'b0, cpu_clk_en)
    cmd(`OMC_CMD_MEM);
    `CHK("wait mem", 1'b0, dbg_cmd_accept)
    cmd(`OMC_CMD_MEM_STAT);
    `CHK("wait status", 1'b1, dbg_cmd_error)
    @(posedge aclk) irq_request <= 1;
    wait_on(0);
    `CHK("wait exit", 1'b1, cpu_clk_en)
    @(posedge aclk) irq_request <= 0;
    pulse(4'h1);
    cmd(`OMC_CMD_HALT);
    `CHK("wait halt", 1'b1, cpu_halted)
    cmd(`OMC_CMD_RESUME);
    pulse(4'h2);
    `CHK("illegal", 1'b1, illegal_op_reset)
    $display("done: wait");
    do_reset(1);
    axw(`OMC_OFF_CFG, 32'h0000_000f, 2'h0);
    pulse(4'h2);
    `CHK("light", 1'b0, core_power_off)
    `CHK("stopped", 1'b0, cpu_clk_en)
    `CHK("light adc", 1'b0, adc_run_en)
    `CHK("light osc", 1'b0, ics_run_en)
    @(posedge aclk) keypad_interrupt <= 1;
    wait_on(0);
    @(posedge aclk) keypad_interrupt <= 0;
    `CHK("light exit", 1'b1, cpu_clk_en)
    axr(`OMC_OFF_CFG, d);
    `CHK("kept cfg", 34'hf, d)
    axw(`OMC_OFF_CFG, 32'h0000_0013, 2'h0);
    pulse(4'h2);
    `CHK("dbg light", 1'b0, core_power_off)
    `CHK("dbg clock", 1'b1, debug_clk_en)
    `CHK("regulator", 1'b1, regulator_full)
    `CHK("dbg osc", 1'b1, ics_run_en)
    cmd(`OMC_CMD_MEM_STAT);
    `CHK("stop status", 1'b1, dbg_cmd_error)
    cmd(`OMC_CMD_HALT);
    `CHK("stop halt", 1'b1, cpu_halted)
    cmd(`OMC_CMD_RESUME);
    $display("done: light stop");
    axw(`OMC_OFF_CFG, 32'h0000_0003, 2'h0);
    pulse(4'h2);
    `CHK("deep", 1'b1, core_power_off)
    `CHK("irq low", 1'b1, irq_force_low)
    `CHK("deep adc", 1'b1, adc_standby)
    `CHK("deep periph", 1'b0, periph_clk_en)
    `CHK("deep timer", 1'b0, rti_run_en)
    @(posedge aclk) keypad_interrupt <= 1;
    repeat (4) @(posedge aclk);
    `CHK("no keypad wake", 1'b1, core_power_off)
    keypad_interrupt <= 0;
    irq_low <= 1;
    wait_on(1);
    irq_low <= 0;
    wait_on(2);
    `CHK("deep vector", 1'b1, vector_fetch)
    `CHK("latched", 1'b1, pin_latch_en)
    axr(`OMC_OFF_PMC, d);
    `CHK("flag", 34'h5, d)
    axr(`OMC_OFF_CFG, d);
    `CHK("cfg default", 34'h0, d)
    axw(`OMC_OFF_PMC, 32'h0000_0002, 2'h0);
    axr(`OMC_OFF_PMC, d);
    `CHK("acked", 34'h0, d)
    `CHK("open", 1'b0, pin_latch_en)
    $display("done: deep stop");
    stop_test();
  end
endmodule
